// ### logic/usf_defs.vh
`ifndef USF_DEFS_VH
`define USF_DEFS_VH
// register offsets
`define USF_ADDR_STATUS 4'h0
`define USF_ADDR_CTRL 4'h1
`define USF_ADDR_RXBUF 4'h2
`define USF_ADDR_TXBUF 4'h3
`define USF_ADDR_IRQ_STAT 4'h4
`define USF_ADDR_IRQ_MASK 4'h5
// status bit positions
`define USF_BIT_TXE 7
`define USF_BIT_RXF 6
`define USF_BIT_OVR 5
`define USF_BIT_FRM 4
`define USF_BIT_PAR 3
`define USF_BIT_TRANSMIT_FINISHED_FLAG 2
`define USF_BIT_MPR 1
`define USF_BIT_MPT 0
`define USF_STATUS_RESET 8'h84
// control bit positions
`define USF_CTL_RXON 0
`define USF_CTL_TXON 1
`define USF_CTL_SYNC 2
`define USF_CTL_PAREN 3
`define USF_CTL_PODD 4
`define USF_CTL_STOP2 5
`define USF_CTL_MPEN 6
`define USF_CTRL_RESET 8'h00
// bit time in clock cycles
`define USF_BIT_CYCLES 16'h0010
`endif

// ### logic/usf_top.v
// Functional notes
// - Stop bit sampled 0 at end of async reception sets framing fault flag.
// - Framing flag clears only by writing 0 after reading 1; resets to 0.
// - Clearing receiver enable leaves framing, parity, overrun flags unchanged.
// - With two stop bits only the first is checked.
// - Framing error: character still stored, buffer-full not raised.
// - Framing flag set halts reception; sync mode halts transmit as well.
// - After overrun buffer keeps old character; new one discarded.
// - Overrun flag set halts reception; sync mode halts transmit too.
// - Async with parity: mismatch against odd/even select sets parity flag.
// - Parity flag clears by writing 0 after reading 1; resets to 0.
// - Parity error: character stored without buffer-full; reception stops.
// - Transmit-finished clears on buffer-empty clear or transmit buffer write.
// - Transmit-finished sets on tx disable or empty at last bit; resets 1.
// - Transmit-finished is read-only.
// - Received multiproc bit captured per character except on overrun, read-only, kept on rx off.
// - Async multiproc transmit appends the written transmit multiproc bit.
// - Transmit multiproc bit ignored in sync, mp off, or idle.
// - Overrun, framing, parity flags clear only by 0 write after reading 1; writing 1 ignored.
`timescale 1ns/1ps
`include "usf_defs.vh"
module usf_top #(
  parameter BIT_CYCLES = `USF_BIT_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // serial line and interrupt
  input wire rx_pin,
  output reg tx_pin,
  output reg irq
);

////////////////////////////////////////////////////////////////////////
reg rx_s1_q;
reg rx_s2_q;
always @(posedge clk) begin
  if (rst) begin
    rx_s1_q <= 1'b1;
    rx_s2_q <= 1'b1;
  end else begin
    rx_s1_q <= rx_pin;
    rx_s2_q <= rx_s1_q;
  end
end

reg [7:0] ctrl_q;
reg [7:0] rxbuf_q;
reg [7:0] txbuf_q;
reg txe_q;
reg rxf_q;
reg ovr_q;
reg frm_q;
reg par_q;
reg transmit_finished_flag_q;
reg mpr_q;
reg mpt_q;
reg [7:0] armed_q;
reg [7:0] ist_q;
reg [7:0] imask_q;
wire rx_on = ctrl_q[`USF_CTL_RXON];
wire tx_on = ctrl_q[`USF_CTL_TXON];
wire sync_m = ctrl_q[`USF_CTL_SYNC];
wire mp_on = ctrl_q[`USF_CTL_MPEN] & ~sync_m;
wire err_stop = frm_q | par_q | ovr_q;
wire rx_allowed = rx_on & ~err_stop;
wire tx_allowed = tx_on & ~(sync_m & (frm_q | ovr_q));
wire [7:0] status = {txe_q, rxf_q, ovr_q, frm_q, par_q, transmit_finished_flag_q, mpr_q, mpt_q};

// strobe aimed at one register index
function hit;
  input strobe;
  input [3:0] a;
  input [3:0] target;
  begin
    hit = strobe & (a == target);
  end
endfunction

function clr_ok;
  input [7:0] w;
  input [7:0] arm;
  input integer b;
  begin
    clr_ok = ~w[b] & arm[b];
  end
endfunction

wire wr_st = hit(wr, addr, `USF_ADDR_STATUS);
wire rd_st = hit(rd, addr, `USF_ADDR_STATUS);
wire wr_tx = hit(wr, addr, `USF_ADDR_TXBUF);
wire rd_rx = hit(rd, addr, `USF_ADDR_RXBUF);
wire wr_ctl = hit(wr, addr, `USF_ADDR_CTRL);
wire wr_msk = hit(wr, addr, `USF_ADDR_IRQ_MASK);
wire rd_ist = hit(rd, addr, `USF_ADDR_IRQ_STAT);

////////////////////////////////////////////////////////////////////////
// receiver: start, 8 data, optional parity, optional mp bit, stop
localparam RS_IDLE = 5'b00001;
localparam RS_START = 5'b00010;
localparam RS_BITS = 5'b00100;
localparam RS_STOP = 5'b01000;
localparam RS_SKIP = 5'b10000;
reg [4:0] rs_q;
reg [15:0] rcnt_q;
reg [3:0] ridx_q;
reg [9:0] rsh_q;
reg r_done;
reg r_frm, r_par;
wire [3:0] rx_nbits = 4'd8 + {3'd0, ctrl_q[`USF_CTL_PAREN]} + {3'd0, mp_on};
wire rx_mid = (rcnt_q == (BIT_CYCLES[15:0] >> 1));
// runs past the second stop, so a low level there never looks like a start
wire [15:0] skip_last = BIT_CYCLES[15:0] + (BIT_CYCLES[15:0] >> 1) - 16'h0001;

always @(posedge clk) begin
  if (rst) begin
    rs_q <= RS_IDLE;
    rcnt_q <= 16'h0000;
    ridx_q <= 4'h0;
    rsh_q <= 10'h000;
  end else begin
    case (rs_q)
      RS_IDLE: begin
        rcnt_q <= 16'h0000;
        ridx_q <= 4'h0;
        if (rx_allowed && !sync_m && !rx_s2_q)
          rs_q <= RS_START;
      end
      RS_START: begin
        rcnt_q <= rcnt_q + 16'h0001;
        if (rx_mid) begin
          rcnt_q <= 16'h0000;
          rs_q <= rx_s2_q ? RS_IDLE : RS_BITS;
        end
      end
      RS_BITS: begin
        rcnt_q <= rcnt_q + 16'h0001;
        if (rcnt_q == BIT_CYCLES[15:0] - 16'h0001) begin
          rcnt_q <= 16'h0000;
          rsh_q[ridx_q] <= rx_s2_q;
          ridx_q <= ridx_q + 4'h1;
          if (ridx_q == rx_nbits - 4'h1)
            rs_q <= RS_STOP;
        end
      end
      RS_STOP: begin
        rcnt_q <= rcnt_q + 16'h0001;
        if (rcnt_q == BIT_CYCLES[15:0] - 16'h0001) begin
          rcnt_q <= 16'h0000;
          // second stop bit is waited out but never checked
          rs_q <= ctrl_q[`USF_CTL_STOP2] ? RS_SKIP : RS_IDLE;
        end
      end

      RS_SKIP: begin
        rcnt_q <= rcnt_q + 16'h0001;
        if (rcnt_q == skip_last)
          rs_q <= RS_IDLE;
      end

      default: rs_q <= RS_IDLE;
    endcase
  end
end

always @* begin
  r_done = (rs_q == RS_STOP) && (rcnt_q == BIT_CYCLES[15:0] - 16'h0001);
  r_frm = r_done && !rx_s2_q;
  r_par = r_done && ctrl_q[`USF_CTL_PAREN] &&
    ((^rsh_q[8:0]) != ctrl_q[`USF_CTL_PODD]);
end
wire r_bad = r_frm | r_par;
wire r_ovr = r_done & ~r_bad & rxf_q;
wire r_good = r_done & ~r_bad & ~rxf_q;
wire r_mp = ctrl_q[`USF_CTL_PAREN] ? rsh_q[9] : rsh_q[8];

////////////////////////////////////////////////////////////////////////
// transmitter
localparam TS_IDLE = 3'b001;
localparam TS_LOAD = 3'b010;
localparam TS_SHIFT = 3'b100;
reg [2:0] ts_q;
reg [15:0] tcnt_q;
reg [3:0] tidx_q;
reg [11:0] tsh_q;
reg [3:0] tlen_q;
wire t_par = ^txbuf_q ^ ctrl_q[`USF_CTL_PODD];
wire t_last = (ts_q == TS_SHIFT) && (tidx_q == tlen_q) &&
  (tcnt_q == BIT_CYCLES[15:0] - 16'h0001);
reg [11:0] t_frame;
reg [3:0] t_len;
always @* begin
  t_frame = {4'hf, txbuf_q};
  t_len = 4'd9;
  if (ctrl_q[`USF_CTL_PAREN]) begin
    t_frame[8] = t_par;
    t_len = t_len + 4'd1;
  end
  if (mp_on) begin
    t_frame[t_len - 4'd1] = mpt_q;
    t_len = t_len + 4'd1;
  end
  t_len = t_len + {3'd0, ctrl_q[`USF_CTL_STOP2]};
end

always @(posedge clk) begin
  if (rst) begin
    ts_q <= TS_IDLE;
    tcnt_q <= 16'h0000;
    tidx_q <= 4'h0;
    tsh_q <= 12'hfff;
    tlen_q <= 4'h0;
    tx_pin <= 1'b1;
  end else begin
    case (ts_q)
      TS_IDLE: begin
        tx_pin <= 1'b1;
        if (tx_allowed && !txe_q)
          ts_q <= TS_LOAD;
      end
      TS_LOAD: begin
        tsh_q <= t_frame;
        tlen_q <= t_len;
        tidx_q <= 4'h0;
        tcnt_q <= 16'h0000;
        tx_pin <= 1'b0;
        ts_q <= TS_SHIFT;
      end
      TS_SHIFT: begin
        tcnt_q <= tcnt_q + 16'h0001;
        if (tcnt_q == BIT_CYCLES[15:0] - 16'h0001) begin
          tcnt_q <= 16'h0000;
          tidx_q <= tidx_q + 4'h1;
          tx_pin <= tsh_q[tidx_q];
          if (t_last) begin
            tx_pin <= 1'b1;
            ts_q <= (tx_allowed && !txe_q) ? TS_LOAD : TS_IDLE;
          end
        end
        if (!tx_on)
          ts_q <= TS_IDLE;
      end
      default: ts_q <= TS_IDLE;
    endcase
  end
end
wire t_take = (ts_q == TS_LOAD);

////////////////////////////////////////////////////////////////////////
// registers; hardware set wins over software clear
wire clr_txe = wr_st & clr_ok(wdata, armed_q, `USF_BIT_TXE);
wire clr_rxf = wr_st & clr_ok(wdata, armed_q, `USF_BIT_RXF);
wire clr_ovr = wr_st & clr_ok(wdata, armed_q, `USF_BIT_OVR);
wire clr_frm = wr_st & clr_ok(wdata, armed_q, `USF_BIT_FRM);
wire clr_par = wr_st & clr_ok(wdata, armed_q, `USF_BIT_PAR);
wire transmit_finished_flag_set = ~tx_on | (t_last & txe_q);

// events that latch into the interrupt status, same layout as status
wire [7:0] ist_set = {
  t_take,
  r_good,
  r_ovr,
  r_frm,
  r_par,
  t_last & txe_q,
  1'b0,
  1'b0
};

reg [7:0] rd_mux;
always @* begin
  rd_mux = 8'h00;
  if (rd) begin
    case (addr)
      `USF_ADDR_STATUS: rd_mux = status;
      `USF_ADDR_CTRL: rd_mux = ctrl_q;
      `USF_ADDR_RXBUF: rd_mux = rxbuf_q;
      `USF_ADDR_TXBUF: rd_mux = txbuf_q;
      `USF_ADDR_IRQ_STAT: rd_mux = ist_q;
      `USF_ADDR_IRQ_MASK: rd_mux = imask_q;
      default: rd_mux = 8'h00;
    endcase
  end
end

// outputs: read data one cycle after the strobe, irq one cycle behind the masked interrupt status
always @(posedge clk) begin
  if (rst) begin
    rdata <= 8'h00;
    irq <= 1'b0;
  end else begin
    rdata <= rd_mux;
    irq <= |(ist_q & imask_q);
  end
end

always @(posedge clk) begin
  if (rst) begin
    ctrl_q <= `USF_CTRL_RESET;
    rxbuf_q <= 8'h00;
    txbuf_q <= 8'h00;
    {txe_q, rxf_q, ovr_q, frm_q, par_q, transmit_finished_flag_q, mpr_q, mpt_q} <= `USF_STATUS_RESET;
    armed_q <= 8'h00;
    ist_q <= 8'h00;
    imask_q <= 8'h00;
  end else begin
    if (wr_ctl)
      ctrl_q <= wdata;
    if (wr_msk)
      imask_q <= wdata;
    if (wr_tx)
      txbuf_q <= wdata;
    if (wr_st)
      mpt_q <= wdata[`USF_BIT_MPT];
    // a read arms the 1-bits seen; a status write disarms unless a status read is in the same cycle
    if (rd_st)
      armed_q <= status;
    else if (wr_st)
      armed_q <= 8'h00;

    // tx buffer empty
    if (clr_txe || wr_tx)
      txe_q <= 1'b0;
    if (t_take || !tx_on)
      txe_q <= 1'b1;

    // transmit finished, no software write path
    if (clr_txe || wr_tx)
      transmit_finished_flag_q <= 1'b0;
    if (transmit_finished_flag_set)
      transmit_finished_flag_q <= 1'b1;

    // receive side; rx off never touches error flags
    if (clr_rxf || rd_rx)
      rxf_q <= 1'b0;
    if (clr_ovr)
      ovr_q <= 1'b0;
    if (clr_frm)
      frm_q <= 1'b0;
    if (clr_par)
      par_q <= 1'b0;

    if (r_frm)
      frm_q <= 1'b1;
    if (r_par)
      par_q <= 1'b1;
    if (r_ovr)
      ovr_q <= 1'b1;
    if (r_bad)
      rxbuf_q <= rsh_q[7:0];
    if (r_good) begin
      rxbuf_q <= rsh_q[7:0];
      rxf_q <= 1'b1;
    end
    if (r_done && !r_ovr && mp_on)
      mpr_q <= r_mp;

    // interrupt status, cleared by reading it; an event in that cycle still lands
    ist_q <= (rd_ist ? 8'h00 : ist_q) | ist_set;
  end
end

endmodule

// ### tb/usf_checker.sv
`timescale 1ns/1ps
module usf_checker #(
  parameter BIT_CYCLES = 16
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // serial line and interrupt
  input wire rx_pin,
  input wire tx_pin,
  input wire irq
);
  reg fresh_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // no write since reset, so nothing can have moved the flags
  always @(posedge clk) begin
    if (rst) fresh_q <= 1'b1;
    else if (wr) fresh_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////
  reset_status_a:
    assert property (fresh_q && rd && addr == 4'h0 |=> rdata == 8'h84)
    else $error("status after reset wrong");
  reset_outputs_a: assert property ($fell(rst) |-> !irq && tx_pin && rdata == 8'h00)
    else $error("outputs after reset wrong");
  idle_rdata_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read");
  unmapped_read_a: assert property (rd && addr > 4'h5 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  transmit_multiproc_bit_rw_a:
    assert property (wr && addr == 4'h0 ##1 !wr ##1 rd && addr == 4'h0
      |=> rdata[0] == $past(wdata[0], 3))
    else $error("transmit mp bit not kept");
  irq_clear_a: assert property (rd && addr == 4'h4 |=> ##1 !irq)
    else $error("irq not cleared by status read");
  // repetitions sized for the bench's BIT_CYCLES of 4
  start_hold_a: assert property ($fell(tx_pin) |-> !tx_pin [*4])
    else $error("low bit too short");
  stop_hold_a: assert property ($rose(tx_pin) |-> tx_pin [*4])
    else $error("high bit too short");
  cover property ($fell(tx_pin));
  cover property ($rose(irq));
  cover property (rd && addr == 4'h4);
endmodule
bind usf_top usf_checker #(.BIT_CYCLES(BIT_CYCLES)) chk_u (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin),
  .tx_pin(tx_pin), .irq(irq));

// ### tb/usf_station.sv
`timescale 1ns/1ps
module usf_station #(
  parameter BC = 4
) (
  // clock
  input wire clk,
  // serial lines
  output reg rx_pin,
  input wire tx_pin
);
  integer i;
  // line idles high between frames
  initial rx_pin = 1'b1;
  ////////////////////////////////////////////////////////////
  task send(input [10:0] v, input integer n);
    @(posedge clk);
    for (i = 0; i < n; i = i + 1) begin
      rx_pin <= v[i];
      repeat (BC) @(posedge clk);
    end
    rx_pin <= 1'b1;
  endtask
  // bounded wait: a missing frame leaves f zero
  task grab(output [9:0] f);
    f = 10'h000;
    for (i = 0; i < 400 && tx_pin; i = i + 1) @(posedge clk);
    if (!tx_pin) begin
      repeat (BC / 2) @(posedge clk);
      for (i = 0; i < 10; i = i + 1) begin
        repeat (BC) @(posedge clk);
        f[i] = tx_pin;
      end
    end
  endtask
endmodule

// ### tb/uart_status_error_flags_bench.sv
`timescale 1ns/1ps
module uart_status_error_flags_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rdv = 1'b0;
  wire [7:0] rdata;
  wire rx_pin;
  wire tx_pin;
  wire irq;
  reg [15:0] q[$];
  reg [15:0] t;
  reg [31:0] seed = 32'h0b7a_64eb;
  reg [7:0] d;
  reg [7:0] e;
  reg [9:0] f;
  integer mismatches = 0;
  integer checked = 0;
  always #2.5 clk = ~clk;
  usf_top #(.BIT_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  usf_station #(.BC(4)) stn_u (.clk(clk), .rx_pin(rx_pin), .tx_pin(tx_pin));
  ////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task rnd;
    seed = lfsr(seed);
    d = seed[7:0];
  endtask
  task chk(input [9:0] x, input [9:0] g);
    checked = checked + 1;
    if (g !== x) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: exp %h got %h", $time, x, g);
    end
  endtask
  task wr_(input [3:0] a, input [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // expected value and mask are queued for the read monitor
  task rd_(input [3:0] a, input [7:0] x, input [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back({m, x});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task frame(input [10:0] v, input integer n);
    stn_u.send(v, n);
    repeat (8) @(posedge clk);
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    rdv <= rd;
    if (rdv) begin
      t = q.pop_front();
      chk({2'b00, t[7:0]}, {2'b00, rdata & t[15:8]});
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches = mismatches + 1;
    conclude;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_(4'h0, 8'h84, 8'hff);
    rd_(4'hf, 8'h00, 8'hff);
    wr_(4'h5, 8'h10);
    wr_(4'h1, 8'h09);
    rnd;
    frame({1'b1, ^d, d, 1'b0}, 11);
    rd_(4'h0, 8'hc4, 8'hff);
    rd_(4'h2, d, 8'hff);
    rnd;
    e = d;
    frame({1'b1, ~^d, d, 1'b0}, 11);
    rnd;
    frame({1'b1, ^d, d, 1'b0}, 11);
    rd_(4'h0, 8'h8c, 8'hff);
    rd_(4'h2, e, 8'hff);
    wr_(4'h1, 8'h08);
    rd_(4'h0, 8'h8c, 8'hff);
    wr_(4'h0, 8'hff);
    wr_(4'h0, 8'hf7);
    rd_(4'h0, 8'h8d, 8'hff);
    wr_(4'h0, 8'hf6);
    rd_(4'h0, 8'h84, 8'hff);
    wr_(4'h1, 8'h21);
    rnd;
    frame({2'b01, d, 1'b0}, 11);
    rd_(4'h0, 8'hc4, 8'hff);
    rd_(4'h2, d, 8'hff);
    rd_(4'h4, 8'h00, 8'h00);
    chk(10'h000, {9'h000, irq});
    rnd;
    frame({2'b10, d, 1'b0}, 11);
    chk(10'h001, {9'h000, irq});
    rd_(4'h0, 8'h94, 8'hff);
    rd_(4'h2, d, 8'hff);
    rd_(4'h4, 8'h10, 8'h10);
    wr_(4'h0, 8'hee);
    rd_(4'h0, 8'h84, 8'hff);
    chk(10'h000, {9'h000, irq});
    wr_(4'h1, 8'h01);
    rnd;
    e = d;
    frame({2'b01, d, 1'b0}, 10);
    rnd;
    frame({2'b01, d, 1'b0}, 10);
    rd_(4'h0, 8'he4, 8'hff);
    rd_(4'h2, e, 8'hff);
    wr_(4'h0, 8'hde);
    rd_(4'h0, 8'h84, 8'hff);
    wr_(4'h1, 8'h41);
    rnd;
    frame({2'b11, d, 1'b0}, 11);
    rd_(4'h0, 8'hc6, 8'hff);
    rd_(4'h2, d, 8'hff);
    wr_(4'h1, 8'h42);
    wr_(4'h0, 8'hfe);
    rnd;
    fork
      stn_u.grab(f);
      begin
        wr_(4'h3, d);
        rd_(4'h0, 8'h00, 8'h04);
      end
    join
    chk({2'b10, d}, f);
    repeat (8) @(posedge clk);
    rd_(4'h0, 8'h86, 8'hff);
    wr_(4'h0, 8'hfb);
    rd_(4'h0, 8'h87, 8'hff);
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule
